/* File: src/ddr3_command_timing_enforcer.sv */
// ddr3 command timing enforcer: apb timing registers and command gate
`timescale 1ns/1ps
// Behaviour
// - activates to different banks spaced by trrd
// - at most four activates per tfaw window
// - write to read same bank waits twtr
// - read to precharge same rank waits trtp
// - no activate until trfc after refresh
// - refresh owed every trefi, issued once all banks are closed
// - read or write waits trcd after activate
// - precharge waits tras after activate
// - activate waits trp after precharge
// - precharge waits twr after write ends
module ddr3_command_timing_enforcer (
   input  wire logic                          ref_clk,     // memory clock
   input  wire logic                          rst_n,       // async reset
   input  wire logic                          psel,        // apb select
   input  wire logic                          penable,     // apb enable
   input  wire logic                          pwrite,      // apb direction
   input  wire logic [ddr3_timing_pkg::AW-1:0] paddr,      // byte address
   input  wire logic [ddr3_timing_pkg::DW-1:0] pwdata,     // write data
   output logic      [ddr3_timing_pkg::DW-1:0] prdata,     // read data
   output logic                               pready,      // apb ready
   output logic                               pslverr,     // unmapped
   input  wire ddr3_timing_pkg::mem_cmd_t     req,         // scheduler ask
   output logic                               req_taken,   // req accepted
   output ddr3_timing_pkg::mem_cmd_t          cmd_out,     // to the dram
   output logic                               refresh_due  // refresh owed
);
   import ddr3_timing_pkg::*;

   timing_cfg_t   cfg, next_cfg;            // spacings in cycles
   logic [DW-1:0] next_prdata;              // read answer
   logic          next_pready;              // second access cycle
   logic          next_slverr;              // unmapped answer
   logic          acc_done;                 // access completes this edge
   logic          hit;                      // address is mapped

   logic [CW-1:0] rrd, next_rrd;            // since last activate
   logic [CW-1:0] rtp, next_rtp;            // since last read
   logic [CW-1:0] rfc, next_rfc;            // since last refresh
   logic [CW-1:0] refi, next_refi;          // to next refresh
   logic [CW-1:0] faw [NFAW];               // one per recent activate
   logic [CW-1:0] next_faw [NFAW];
   logic [CW-1:0] rcd [NBANK];              // per bank timers
   logic [CW-1:0] next_rcd [NBANK];
   logic [CW-1:0] ras [NBANK];
   logic [CW-1:0] next_ras [NBANK];
   logic [CW-1:0] rp [NBANK];
   logic [CW-1:0] next_rp [NBANK];
   logic [CW-1:0] wtr [NBANK];
   logic [CW-1:0] next_wtr [NBANK];
   logic [CW-1:0] wr [NBANK];
   logic [CW-1:0] next_wr [NBANK];
   logic [NBANK-1:0] bank_open, next_open;  // row open per bank
   logic [NBANK-1:0] rcd_z, ras_z, rp_z;    // timers expired
   logic [NBANK-1:0] wtr_z, wr_z;
   logic [NFAW-1:0]  faw_z;                 // free window slots
   logic          next_due;                 // refresh owed
   logic          next_taken;               // request goes out
   logic          refresh_go;               // own refresh goes out
   mem_cmd_t      next_cmd;                 // command for next edge

   // apb decode and register writes; rounding happens on write
   assign acc_done = psel && penable && pready;
   assign hit = (paddr <= REG_STATUS) && (paddr[1:0] == 2'h0);

   always_comb begin
      next_cfg    = cfg;
      next_pready = psel && penable && !pready;
      next_prdata = prdata;
      next_slverr = 1'b0;
      if (next_pready) begin
         // answer is set up one cycle into the access phase
         next_slverr = !hit;
         next_prdata = '0;
         case (paddr)
            REG_RRD:    next_prdata[CW-1:0] = cfg.rrd;
            REG_FAW:    next_prdata[CW-1:0] = cfg.faw;
            REG_WTR:    next_prdata[CW-1:0] = cfg.wtr;
            REG_RTP:    next_prdata[CW-1:0] = cfg.rtp;
            REG_RFC:    next_prdata[CW-1:0] = cfg.rfc;
            REG_REFI:   next_prdata[CW-1:0] = cfg.refi;
            REG_RCD:    next_prdata[CW-1:0] = cfg.rcd;
            REG_RAS:    next_prdata[CW-1:0] = cfg.ras;
            REG_RP:     next_prdata[CW-1:0] = cfg.rp;
            REG_WR:     next_prdata[CW-1:0] = cfg.wr;
            REG_WL:     next_prdata[CW-1:0] = cfg.wl;
            REG_STATUS: begin
               // open banks, refresh owed, refresh countdown
               next_prdata[NBANK-1:0]        = bank_open;
               next_prdata[ST_DUE]           = refresh_due;
               next_prdata[ST_REFI+:CW]      = refi;
            end
            default: next_prdata = '0;
         endcase
      end
      if (acc_done && pwrite) begin
         case (paddr)
            REG_RRD:  next_cfg.rrd  = pwdata[CW-1:0];
            REG_FAW:  next_cfg.faw  = to_cyc(pwdata[CW-1:0], PS_PER_NS);
            REG_WTR:  next_cfg.wtr  = pwdata[CW-1:0];
            REG_RTP:  next_cfg.rtp  = pwdata[CW-1:0];
            REG_RFC:  next_cfg.rfc  = to_cyc(pwdata[CW-1:0], PS_PER_NS);
            REG_REFI: next_cfg.refi = to_cyc(pwdata[CW-1:0], PS_PER_US);
            REG_RCD:  next_cfg.rcd  = to_cyc(pwdata[CW-1:0], PS_PER_NS);
            REG_RAS:  next_cfg.ras  = to_cyc(pwdata[CW-1:0], PS_PER_NS);
            REG_RP:   next_cfg.rp   = to_cyc(pwdata[CW-1:0], PS_PER_NS);
            REG_WR:   next_cfg.wr   = to_cyc(pwdata[CW-1:0], PS_PER_NS);
            REG_WL:   next_cfg.wl   = pwdata[CW-1:0];
            default:  next_cfg = cfg;
         endcase
      end
   end

   // apb state registers
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg     <= '{RST_RRD, RST_FAW, RST_WTR, RST_RTP, RST_RFC, RST_REFI,
                      RST_RCD, RST_RAS, RST_RP, RST_WR, RST_WL};
         prdata  <= '0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         cfg     <= next_cfg;
         prdata  <= next_prdata;
         pready  <= next_pready;
         pslverr <= next_slverr;
      end
   end

   // command gate: timers, bank state and the issued command
   always_comb begin
      logic           ok;       // request meets every spacing
      logic           placed;   // window slot already taken
      logic [BW-1:0]  b;        // bank of issued command
      ok     = 1'b0;
      placed = 1'b0;
      b      = '0;
      for (int i = 0; i < NBANK; i++) begin
         rcd_z[i] = (rcd[i] == CNT_ZERO);
         ras_z[i] = (ras[i] == CNT_ZERO);
         rp_z[i]  = (rp[i] == CNT_ZERO);
         wtr_z[i] = (wtr[i] == CNT_ZERO);
         wr_z[i]  = (wr[i] == CNT_ZERO);
         next_rcd[i] = dec(rcd[i]);
         next_ras[i] = dec(ras[i]);
         next_rp[i]  = dec(rp[i]);
         next_wtr[i] = dec(wtr[i]);
         next_wr[i]  = dec(wr[i]);
      end
      for (int i = 0; i < NFAW; i++) begin
         faw_z[i]    = (faw[i] == CNT_ZERO);
         next_faw[i] = dec(faw[i]);
      end
      next_rrd  = dec(rrd);
      next_rtp  = dec(rtp);
      next_rfc  = dec(rfc);
      next_open = bank_open;
      next_due  = refresh_due;
      // periodic refresh owed every refi cycles
      if (refi == CNT_ZERO) begin
         next_refi = ld(cfg.refi);
         next_due  = 1'b1;
      end else begin
         next_refi = dec(refi);
      end
      // own refresh once every bank is closed and rested
      refresh_go = refresh_due && (bank_open == '0) && (&rp_z)
                   && (rfc == CNT_ZERO);
      case (req.kind)
         CMD_ACT: ok = !bank_open[req.bank] && (rrd == CNT_ZERO)
                       && (faw_z != '0)
                       && (rfc == CNT_ZERO)
                       && rp_z[req.bank]
                       && !refresh_due;
         CMD_RD:  ok = bank_open[req.bank] && rcd_z[req.bank]
                       && wtr_z[req.bank];
         CMD_WR:  ok = bank_open[req.bank] && rcd_z[req.bank];
         CMD_PRE: ok = bank_open[req.bank] && ras_z[req.bank]
                       && (rtp == CNT_ZERO)
                       && wr_z[req.bank];
         default: ok = 1'b0;
      endcase
      // a taken request is dropped by the scheduler next cycle
      next_taken = req.valid && !req_taken && !refresh_go && ok;
      if (refresh_go) begin
         next_cmd = '{1'b1, CMD_REF, '0};
      end else if (next_taken) begin
         next_cmd = req;
      end else begin
         next_cmd = '{1'b0, CMD_NOP, '0};
      end
      b = next_cmd.bank;
      if (next_cmd.valid) begin
         case (next_cmd.kind)
            CMD_ACT: begin
               next_rrd     = ld(cfg.rrd);
               next_rcd[b]  = ld(cfg.rcd);
               next_ras[b]  = ld(cfg.ras);
               next_open[b] = 1'b1;
               for (int i = 0; i < NFAW; i++) begin
                  if (faw_z[i] && !placed) begin
                     next_faw[i] = ld(cfg.faw);
                     placed      = 1'b1;
                  end
               end
            end
            CMD_RD:  next_rtp = ld(cfg.rtp);
            CMD_WR: begin
               // counted from the final data beat, wl cycles on
               next_wtr[b] = ld(CW'(cfg.wl + cfg.wtr));
               next_wr[b]  = ld(CW'(cfg.wl + cfg.wr));
            end
            CMD_PRE: begin
               next_rp[b]   = ld(cfg.rp);
               next_open[b] = 1'b0;
            end
            CMD_REF: begin
               next_rfc = ld(cfg.rfc);
               // a new period ending now keeps the flag set
               if (refi != CNT_ZERO) begin
                  next_due = 1'b0;
               end
            end
            default: next_open = bank_open;
         endcase
      end
   end

   // command gate registers
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rrd         <= CNT_ZERO;
         rtp         <= CNT_ZERO;
         rfc         <= CNT_ZERO;
         refi        <= RST_REFI;
         faw         <= '{default: CNT_ZERO};
         rcd         <= '{default: CNT_ZERO};
         ras         <= '{default: CNT_ZERO};
         rp          <= '{default: CNT_ZERO};
         wtr         <= '{default: CNT_ZERO};
         wr          <= '{default: CNT_ZERO};
         bank_open   <= '0;
         refresh_due <= 1'b0;
         req_taken   <= 1'b0;
         cmd_out     <= '{1'b0, CMD_NOP, '0};
      end else begin
         rrd         <= next_rrd;
         rtp         <= next_rtp;
         rfc         <= next_rfc;
         refi        <= next_refi;
         faw         <= next_faw;
         rcd         <= next_rcd;
         ras         <= next_ras;
         rp          <= next_rp;
         wtr         <= next_wtr;
         wr          <= next_wr;
         bank_open   <= next_open;
         refresh_due <= next_due;
         req_taken   <= next_taken;
         cmd_out     <= next_cmd;
      end
   end

   // helper: cycles since the last activate seen on the bus
   logic [CW-1:0] act_age;
   logic          cmd_act;
   assign cmd_act = cmd_out.valid && (cmd_out.kind == CMD_ACT);
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         act_age <= CNT_MAX;
      end else if (cmd_act) begin
         act_age <= CNT_ONE;
      end else if (act_age != CNT_MAX) begin
         act_age <= act_age + CNT_ONE;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   rrd_gap_a: assert property (cmd_act |-> act_age >= cfg.rrd)
      else $error("activates closer than trrd");
   faw_slot_a: assert property (next_cmd.valid && next_cmd.kind == CMD_ACT
      |-> faw_z != '0)
      else $error("fifth activate inside tfaw");
   wtr_wait_a: assert property (next_cmd.valid && next_cmd.kind == CMD_RD
      |-> wtr_z[next_cmd.bank])
      else $error("read too soon after write");
   rtp_wait_a: assert property (rtp != CNT_ZERO
      |=> !(cmd_out.valid && cmd_out.kind == CMD_PRE))
      else $error("precharge too soon after read");
   rfc_hold_a: assert property (rfc != CNT_ZERO |=> !cmd_act)
      else $error("activate inside trfc");
   refi_due_a: assert property (refi == CNT_ZERO |=> refresh_due)
      else $error("refresh not flagged at trefi");
   rcd_wait_a: assert property (next_cmd.valid
      && (next_cmd.kind == CMD_RD || next_cmd.kind == CMD_WR)
      |-> rcd_z[next_cmd.bank])
      else $error("column access inside trcd");
   ras_pre_a: assert property (next_cmd.valid && next_cmd.kind == CMD_PRE
      |-> ras_z[next_cmd.bank] && wr_z[next_cmd.bank])
      else $error("precharge inside tras or twr");
   rp_act_a: assert property (next_cmd.valid && next_cmd.kind == CMD_ACT
      |-> rp_z[next_cmd.bank])
      else $error("activate inside trp");
   rcd_round_a: assert property (acc_done && pwrite && paddr == REG_RCD
      |=> longint'(cfg.rcd) * CLK_PERIOD_PS
          >= longint'($past(pwdata[CW-1:0])) * PS_PER_NS)
      else $error("trcd rounded down");

   ref_c: cover property (cmd_out.valid && cmd_out.kind == CMD_REF);
   wr_rd_c: cover property (cmd_out.valid && cmd_out.kind == CMD_WR
      ##[1:40] cmd_out.valid && cmd_out.kind == CMD_RD);
   faw_full_c: cover property (next_cmd.valid && faw_z == '0);
endmodule

/* File: src/ddr3_timing_pkg.sv */
// package: command codes, register map and timing settings
package ddr3_timing_pkg;
   localparam longint CLK_PERIOD_PS = 10000; // 100 MHz memory clock
   localparam longint PS_PER_NS     = 1000;
   localparam longint PS_PER_US     = 1000000;
   localparam int     NBANK         = 8;     // banks in the rank
   localparam int     BW            = 3;     // bank index width
   localparam int     CW            = 16;    // timer width
   localparam int     NFAW          = 4;     // activates per window
   localparam int     AW            = 8;     // apb address width
   localparam int     DW            = 32;    // apb data width
   localparam logic [CW-1:0] CNT_ZERO = 16'h0000;
   localparam logic [CW-1:0] CNT_ONE  = 16'h0001;
   localparam logic [CW-1:0] CNT_MAX  = 16'hFFFF;
   // register byte offsets
   localparam logic [AW-1:0] REG_RRD    = 8'h00; // cycles
   localparam logic [AW-1:0] REG_FAW    = 8'h04; // ns
   localparam logic [AW-1:0] REG_WTR    = 8'h08; // cycles
   localparam logic [AW-1:0] REG_RTP    = 8'h0C; // cycles
   localparam logic [AW-1:0] REG_RFC    = 8'h10; // ns
   localparam logic [AW-1:0] REG_REFI   = 8'h14; // us
   localparam logic [AW-1:0] REG_RCD    = 8'h18; // ns
   localparam logic [AW-1:0] REG_RAS    = 8'h1C; // ns
   localparam logic [AW-1:0] REG_RP     = 8'h20; // ns
   localparam logic [AW-1:0] REG_WR     = 8'h24; // ns
   localparam logic [AW-1:0] REG_WL     = 8'h28; // cycles
   localparam logic [AW-1:0] REG_STATUS = 8'h2C; // read only
   // status field positions
   localparam int ST_DUE  = 8;
   localparam int ST_REFI = 16;
   // reset values, in cycles
   localparam logic [CW-1:0] RST_RRD  = 16'h0004;
   localparam logic [CW-1:0] RST_FAW  = 16'h0004;
   localparam logic [CW-1:0] RST_WTR  = 16'h0004;
   localparam logic [CW-1:0] RST_RTP  = 16'h0004;
   localparam logic [CW-1:0] RST_RFC  = 16'h001A;
   localparam logic [CW-1:0] RST_REFI = 16'h030C;
   localparam logic [CW-1:0] RST_RCD  = 16'h0002;
   localparam logic [CW-1:0] RST_RAS  = 16'h0004;
   localparam logic [CW-1:0] RST_RP   = 16'h0002;
   localparam logic [CW-1:0] RST_WR   = 16'h0002;
   localparam logic [CW-1:0] RST_WL   = 16'h0008;
   typedef enum logic [2:0] {
      CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_REF
   } cmd_kind_t;
   // one command on the memory command bus
   typedef struct packed {
      logic            valid;
      cmd_kind_t       kind;
      logic [BW-1:0]   bank;
   } mem_cmd_t;
   // enforced spacings, all in cycles
   typedef struct packed {
      logic [CW-1:0] rrd, faw, wtr, rtp, rfc, refi;
      logic [CW-1:0] rcd, ras, rp, wr, wl;
   } timing_cfg_t;
   // time in units of unit_ps to cycles, rounded up, saturating
   function automatic logic [CW-1:0] to_cyc(input logic [CW-1:0] v,
                                            input longint unit_ps);
      longint t;
      t = (longint'(v) * unit_ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
      return (t > longint'(CNT_MAX)) ? CNT_MAX : t[CW-1:0];
   endfunction
   // timer load for a spacing of n edges
   function automatic logic [CW-1:0] ld(input logic [CW-1:0] n);
      return (n == CNT_ZERO) ? CNT_ZERO : n - CNT_ONE;
   endfunction
   // count down, holding at zero
   function automatic logic [CW-1:0] dec(input logic [CW-1:0] n);
      return (n == CNT_ZERO) ? CNT_ZERO : n - CNT_ONE;
   endfunction
endpackage

/* File: testbench/dram_cmd_model.sv */
// dram side model: watches the command bus and flags spacing faults
`timescale 1ns/1ps
module dram_cmd_model (
   input  wire logic                         ref_clk, // memory clock
   input  wire logic                         rst_n,   // async reset
   input  wire ddr3_timing_pkg::mem_cmd_t    cmd,     // command bus
   input  wire ddr3_timing_pkg::timing_cfg_t cfg,     // spacings, cycles
   output logic [10:1]                       fault    // sticky, one per kind
);
   import ddr3_timing_pkg::*;
   localparam longint LONG_AGO = -100000; // no earlier command
   longint cyc;             // cycles since reset
   longint t_act [NBANK];   // last activate per bank
   longint t_pre [NBANK];   // last precharge per bank
   longint t_wr  [NBANK];   // last write per bank
   longint t_faw [4];       // last four activates, newest first
   longint t_rd;            // last read, any bank
   longint t_ref;           // last refresh
   logic   ref_seen;        // a refresh was seen
   // true when n cycles passed since t; zero acts as one
   function automatic logic gap(longint t, logic [CW-1:0] n);
      return cyc - t >= ((n == CNT_ZERO) ? 1 : longint'(n));
   endfunction
   // sample the bus each rising edge, stamp and judge each command
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cyc = 0;
         t_rd = LONG_AGO;
         t_ref = LONG_AGO;
         ref_seen = 1'b0;
         fault <= '0;
         for (int i = 0; i < NBANK; i++) begin
            t_act[i] = LONG_AGO;
            t_pre[i] = LONG_AGO;
            t_wr[i] = LONG_AGO;
         end
         for (int i = 0; i < 4; i++) t_faw[i] = LONG_AGO;
      end else begin
         if (cmd.valid) begin
            case (cmd.kind)
               CMD_ACT: begin
                  if (!gap(t_faw[0], cfg.rrd)) fault[1] <= 1'b1;
                  if (!gap(t_faw[3], cfg.faw)) fault[2] <= 1'b1;
                  if (!gap(t_ref, cfg.rfc)) fault[5] <= 1'b1;
                  if (!gap(t_pre[cmd.bank], cfg.rp)) fault[9] <= 1'b1;
                  t_faw = '{cyc, t_faw[0], t_faw[1], t_faw[2]};
                  t_act[cmd.bank] = cyc;
               end
               CMD_RD, CMD_WR: begin
                  if (!gap(t_act[cmd.bank], cfg.rcd)) fault[7] <= 1'b1;
                  if (cmd.kind == CMD_RD &&
                      !gap(t_wr[cmd.bank], cfg.wl + cfg.wtr))
                     fault[3] <= 1'b1;
                  if (cmd.kind == CMD_RD) t_rd = cyc;
                  else t_wr[cmd.bank] = cyc;
               end
               CMD_PRE: begin
                  if (!gap(t_act[cmd.bank], cfg.ras)) fault[8] <= 1'b1;
                  if (!gap(t_rd, cfg.rtp)) fault[4] <= 1'b1;
                  if (!gap(t_wr[cmd.bank], cfg.wl + cfg.wr))
                     fault[10] <= 1'b1;
                  t_pre[cmd.bank] = cyc;
               end
               CMD_REF: begin
                  t_ref = cyc;
                  ref_seen = 1'b1;
               end
               default: ;
            endcase
         end
         // refresh gap may overrun only by the bank closing time
         if (ref_seen && cyc - t_ref > longint'(cfg.refi) + 100)
            fault[6] <= 1'b1;
         cyc = cyc + 1;
      end
   end
endmodule

/* File: testbench/ddr3_command_timing_enforcer_test.sv */
// bench: apb set-up, random command traffic and spacing checks
`timescale 1ns/1ps
module ddr3_command_timing_enforcer_test;
   import ddr3_timing_pkg::*;
   logic          ref_clk, rst_n, psel, penable, pwrite; // clock, apb
   logic [AW-1:0] paddr;                // apb address
   logic [DW-1:0] pwdata, prdata;       // apb data
   logic          pready, pslverr;      // apb answer
   logic          req_taken, refresh_due; // command side flags
   mem_cmd_t      req, cmd_out;         // request and issued command
   timing_cfg_t   cfg;                  // expected spacings for the model
   logic [10:1]   fault;                // model fault flags
   logic [7:0]    bmask = '0;           // banks the bench opened
   logic          pending;              // request waiting for acceptance
   int            error_cnt = 0;        // mismatches
   int            checked = 0;          // comparisons
   logic [31:0]   seed = 32'h0000_5A13; // xorshift state
   // expected cycles per register, in register order
   logic [CW-1:0] cyc_tab [11] = '{RST_RRD, RST_FAW, RST_WTR, RST_RTP,
      RST_RFC, RST_REFI, RST_RCD, RST_RAS, RST_RP, RST_WR, RST_WL};
   assign cfg = {cyc_tab[0], cyc_tab[1], cyc_tab[2], cyc_tab[3], cyc_tab[4],
      cyc_tab[5], cyc_tab[6], cyc_tab[7], cyc_tab[8], cyc_tab[9], cyc_tab[10]};
   ddr3_command_timing_enforcer i_ddr3_command_timing_enforcer (
      .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .req(req),
      .req_taken(req_taken), .cmd_out(cmd_out), .refresh_due(refresh_due));
   dram_cmd_model i_dram_cmd_model (
      .ref_clk(ref_clk), .rst_n(rst_n), .cmd(cmd_out), .cfg(cfg),
      .fault(fault));
   // 100 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // xorshift generator
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // setting in its unit to cycles, rounded up
   function automatic logic [CW-1:0] to_cycles(int i, int v);
      int ps;
      ps = (i == 5) ? v * 1000000 : (i inside {1,4,6,7,8,9}) ? v * 1000
         : v * 10000;
      return CW'((ps + 9999) / 10000);
   endfunction
   // compare and report
   task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] ex);
      checked++;
      if (seen !== ex) begin
         error_cnt++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, ex);
      end
   endtask
   // verdict and end of run
   task automatic finish_test();
      $display("checks %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // one apb transfer, pready waited for under a bound
   task automatic apb(input logic wr, input logic [AW-1:0] a,
      input logic [DW-1:0] d, output logic [DW-1:0] q, output logic err);
      int n;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         error_cnt++;
         finish_test();
      end
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // choose a legal request for the present bank state
   task automatic pick();
      int        b, j;
      cmd_kind_t k;
      b = int'(rnd() % 8);
      k = cmd_kind_t'(1 + rnd() % 4);
      if (refresh_due === 1'b1) k = CMD_PRE; // close banks for refresh
      j = 0;
      while (j < 8 && bmask[(b + j) % 8] == (k == CMD_ACT)) j++;
      if (j == 8) begin
         if (refresh_due === 1'b1) k = CMD_NOP;
         else if (k == CMD_ACT) k = CMD_PRE;
         else k = CMD_ACT;
         j = 0;
      end
      req.valid <= (k != CMD_NOP);
      req.kind <= k;
      req.bank <= BW'((b + j) % 8);
      pending = (k != CMD_NOP);
   endtask
   // main sequence
   initial begin
      logic [DW-1:0] q;
      logic          e;
      int            v, n, wcnt, n_ref;
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      req = '0;
      repeat (6) @(posedge ref_clk);
      rst_n <= 1'b1;
      // reset values of every timing register
      for (int i = 0; i < 11; i++) begin
         apb(1'b0, AW'(4 * i), '0, q, e);
         check(q, {16'h0000, cyc_tab[i]});
      end
      // unmapped read, unaligned write, read-only status
      apb(1'b0, 8'h30, '0, q, e);
      check(e, 1'b1);
      check(q, '0);
      apb(1'b1, 8'h05, 32'hFFFF_FFFF, q, e);
      check(e, 1'b1);
      apb(1'b1, REG_STATUS, 32'h0000_01FF, q, e);
      check(e, 1'b0);
      apb(1'b0, REG_STATUS, '0, q, e);
      check(q[8:0], 9'h000);
      // random settings, read back in cycles
      for (int i = 0; i < 11; i++) begin
         v = 1 + int'(rnd() % 6);
         if (i inside {1,4,6,7,8,9}) v = 1 + int'(rnd() % 70);
         if (i == 5) v = 2 + int'(rnd() % 3);
         if (i == 6) v = 30; // exact multiple, no round-up
         apb(1'b1, AW'(4 * i), DW'(v), q, e);
         cyc_tab[i] = to_cycles(i, v);
         apb(1'b0, AW'(4 * i), '0, q, e);
         check(q, {16'h0000, cyc_tab[i]});
      end
      // random traffic; an activate is withdrawn while refresh is owed
      pending = 1'b0;
      wcnt = 0;
      n_ref = 0;
      for (n = 0; n < 4000 || pending; n++) begin
         @(posedge ref_clk);
         if (cmd_out.valid === 1'b1 && cmd_out.kind == CMD_REF) begin
            n_ref++;
            check(refresh_due, 1'b0);
         end
         if (req_taken === 1'b1) begin
            check(DW'(cmd_out), DW'(req));
            if (req.kind == CMD_ACT) bmask[req.bank] = 1'b1;
            if (req.kind == CMD_PRE) bmask[req.bank] = 1'b0;
            pending = 1'b0;
         end
         if (pending && refresh_due === 1'b1 && req.kind == CMD_ACT)
            pending = 1'b0;
         wcnt = pending ? wcnt + 1 : 0;
         if (wcnt > 600) begin
            error_cnt++;
            finish_test();
         end
         if (!pending) begin
            if (n < 4000) pick();
            else req <= '0;
         end
      end
      apb(1'b0, REG_STATUS, '0, q, e);
      check(q[7:0], bmask);
      check(n_ref >= 4000 / (cyc_tab[5] + 100), 1'b1);
      check(fault[1], 1'b0);
      check(fault[2], 1'b0);
      check(fault[3], 1'b0);
      check(fault[4], 1'b0);
      check(fault[5], 1'b0);
      check(fault[6], 1'b0);
      check(fault[7], 1'b0);
      check(fault[8], 1'b0);
      check(fault[9], 1'b0);
      check(fault[10], 1'b0);
      finish_test();
   end
endmodule
